// file: src/twc_core.v
`timescale 1ns/1ns
`include "twc_map.vh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - master scl period 16+2*divider*4^prescale
// - slave follows scl, ignores divider
// - master high phase starts at real rise
// - 8-bit shift data register
// - hidden ack bit from control register
// - generate and detect start, stop
// - arbitration loss reported to control
// - compare address with own address
// - general call match when enabled
// - match informs control; ack per setting
// - address match works asleep, wakes cpu
// - foreign wake aborts sleep match
// - flag first, status code next cycle
// - no-information code while flag clear
// - scl held low while flag set, except in idle
// - flag on start, address, loss, data
// - flag on slave stop, bus error
// - irq needs flag, enable, global enable
// - write one clears; then operation starts
// - no flag after commanded stop
// - status shows packet done and ack
// - nine-bit packets, msb first, r/w
module twc_core (
   input wire clk_i,
   input wire rst_n_i,
   input wire [2:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [7:0] rdata_o,
   input wire scl_i,
   output wire scl_o,
   output wire scl_oen_o,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oen_o,
   input wire global_irq_en_i,
   input wire sleep_i,
   input wire other_wake_i,
   output wire irq_o,
   output wire wake_o
);

localparam S_IDLE = 11'h001;
localparam S_START = 11'h002;
localparam S_SDAL = 11'h004;
localparam S_RS = 11'h008;
localparam S_LOW = 11'h010;
localparam S_HIGH = 11'h020;
localparam S_HOLD = 11'h040;
localparam S_STOP1 = 11'h080;
localparam S_STOP2 = 11'h100;
localparam S_STOP3 = 11'h200;
localparam S_SLAVE = 11'h400;
// states in which we make start or stop ourselves
localparam OWN_MASK = 11'h38E;

////////////////////////////////////////////////////////////////////////////////
wire scl_s;
wire sda_s;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;

twc_bus_mon u_mon (
   .clk_i(clk_i),
   .rst_n_i(rst_n_i),
   .scl_i(scl_i),
   .sda_i(sda_i),
   .scl_o(scl_s),
   .sda_o(sda_s),
   .scl_rise_o(scl_rise),
   .scl_fall_o(scl_fall),
   .start_o(start_det),
   .stop_o(stop_det)
);

reg [7:0] bit_rate_divider_r;
reg [1:0] prescaler_select_r;
reg [7:0] own_address_r;
reg ack_en_r;
reg sta_r;
reg sto_r;
reg en_r;
reg event_irq_enable_r;
reg flag_r;
reg [7:0] status_r;
reg [7:0] ev_code_r;
reg ev_r;
reg load_r;
reg [7:0] shift_data_r;
reg [10:0] st_r;
reg [14:0] tmr_r;
reg [3:0] cnt_r;
reg master_r;
reg mtx_r;
reg adr_r;
reg stx_r;
reg adr_ph_r;
reg addressed_r;
reg gc_r;
reg lost_r;
reg ack_out_r;
reg ack_in_r;
reg sda_lvl_r;
reg scl_low_r;
reg busy_r;
reg rs_r;
reg go_r;
reg wake_r;
reg rose_r;
reg [7:0] rdata_r;
reg bit_val;
reg [7:0] rd_nxt;

wire clr = wr_i & (addr_i == `TWC_OFS_CTRL) & wdata_i[`TWC_CTL_FLAG];
wire [14:0] half = `TWC_HALF_BASE + ({7'h00, bit_rate_divider_r} << {prescaler_select_r, 1'b0});
wire [14:0] half_end = half - 15'h0001;
// high phase already lost the synchroniser delay
wire [14:0] high_end = half - `TWC_SYNC_LAT - 15'h0001;
wire own_cond = |(st_r & OWN_MASK);
wire tx_now = master_r ? (adr_r | mtx_r) : stx_r;
wire own_hit = shift_data_r[7:1] == own_address_r[7:1];
wire gc_hit = own_address_r[`TWC_OAR_GCE] & (shift_data_r[7:1] == `TWC_GC_ADDR);
wire bus_err = master_r ? (st_r == S_LOW || st_r == S_HIGH) : (cnt_r != 4'h0);

// msb first, ninth bit is acknowledge
always @* begin
   if (cnt_r < `TWC_LAST_BIT) begin
      bit_val = tx_now ? shift_data_r[7] : 1'b1;
   end else begin
      bit_val = tx_now ? 1'b1 : ~ack_out_r;
   end
end

////////////////////////////////////////////////////////////////////////////////
// software registers
always @(posedge clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      bit_rate_divider_r <= `TWC_BITRATE_RST;
      prescaler_select_r <= 2'h0;
      own_address_r <= `TWC_OWNADR_RST;
      ack_en_r <= 1'b0;
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      en_r <= 1'b0;
      event_irq_enable_r <= 1'b0;
   end else if (wr_i) begin
      if (addr_i == `TWC_OFS_BITRATE) begin
         bit_rate_divider_r <= wdata_i;
      end else if (addr_i == `TWC_OFS_STATUS) begin
         prescaler_select_r <= wdata_i[1:0];
      end else if (addr_i == `TWC_OFS_OWNADR) begin
         own_address_r <= wdata_i;
      end else if (addr_i == `TWC_OFS_CTRL) begin
         ack_en_r <= wdata_i[`TWC_CTL_ACK];
         sta_r <= wdata_i[`TWC_CTL_STA];
         sto_r <= wdata_i[`TWC_CTL_STO];
         en_r <= wdata_i[`TWC_CTL_EN];
         event_irq_enable_r <= wdata_i[`TWC_CTL_IE];
      end
   end
end

// flag now, code one cycle later
always @(posedge clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      flag_r <= 1'b0;
      load_r <= 1'b0;
      status_r <= `TWC_ST_NOINFO;
   end else begin
      // write one clears, a new event wins
      flag_r <= ev_r | (flag_r & ~clr);
      load_r <= ev_r;
      if (load_r) begin
         status_r <= ev_code_r;
      end else if (!flag_r) begin
         status_r <= `TWC_ST_NOINFO;
      end
   end
end

always @* begin
   rd_nxt = 8'h00;
   if (addr_i == `TWC_OFS_BITRATE) begin
      rd_nxt = bit_rate_divider_r;
   end else if (addr_i == `TWC_OFS_STATUS) begin
      rd_nxt = {status_r[7:3], 1'b0, prescaler_select_r};
   end else if (addr_i == `TWC_OFS_DATA) begin
      rd_nxt = shift_data_r;
   end else if (addr_i == `TWC_OFS_OWNADR) begin
      rd_nxt = own_address_r;
   end else if (addr_i == `TWC_OFS_CTRL) begin
      rd_nxt = {flag_r, ack_en_r, sta_r, sto_r, 1'b0, en_r, 1'b0, event_irq_enable_r};
   end
end

always @(posedge clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      rdata_r <= 8'h00;
   end else begin
      rdata_r <= rd_i ? rd_nxt : 8'h00;
   end
end

////////////////////////////////////////////////////////////////////////////////
// bus engine
always @(posedge clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      st_r <= S_IDLE;
      tmr_r <= 15'h0000;
      cnt_r <= 4'h0;
      shift_data_r <= `TWC_DATA_RST;
      ev_r <= 1'b0;
      ev_code_r <= `TWC_ST_NOINFO;
      master_r <= 1'b0;
      mtx_r <= 1'b0;
      adr_r <= 1'b0;
      stx_r <= 1'b0;
      adr_ph_r <= 1'b0;
      addressed_r <= 1'b0;
      gc_r <= 1'b0;
      lost_r <= 1'b0;
      ack_out_r <= 1'b0;
      ack_in_r <= 1'b1;
      sda_lvl_r <= 1'b1;
      scl_low_r <= 1'b0;
      busy_r <= 1'b0;
      rs_r <= 1'b0;
      go_r <= 1'b0;
      wake_r <= 1'b0;
      rose_r <= 1'b0;
   end else begin
      ev_r <= 1'b0;
      wake_r <= 1'b0;
      tmr_r <= tmr_r + 15'h0001;
      // detection is never gated by sleep
      if (start_det) begin
         busy_r <= 1'b1;
      end else if (stop_det) begin
         busy_r <= 1'b0;
      end
      // the scl fall that closes a start carries no bit
      if (start_det) begin
         rose_r <= 1'b0;
      end else if (scl_rise) begin
         rose_r <= 1'b1;
      end
      // hidden ack bit loaded from control
      if (clr) begin
         ack_out_r <= wdata_i[`TWC_CTL_ACK];
         go_r <= 1'b1;
      end
      // byte written only while the engine is not shifting
      if (wr_i && addr_i == `TWC_OFS_DATA && (flag_r || st_r == S_IDLE)) begin
         shift_data_r <= wdata_i;
      end
      if (!en_r) begin
         st_r <= S_IDLE;
         master_r <= 1'b0;
         addressed_r <= 1'b0;
         scl_low_r <= 1'b0;
         sda_lvl_r <= 1'b1;
      end else if (sleep_i && other_wake_i && st_r == S_SLAVE && adr_ph_r) begin
         st_r <= S_IDLE;
         sda_lvl_r <= 1'b1;
      end else if ((start_det || stop_det) && !own_cond && bus_err) begin
         ev_r <= 1'b1;
         ev_code_r <= `TWC_ST_BUSERR;
         st_r <= S_IDLE;
         master_r <= 1'b0;
         addressed_r <= 1'b0;
         scl_low_r <= 1'b0;
         sda_lvl_r <= 1'b1;
      end else if (start_det && !own_cond && !master_r) begin
         if (addressed_r) begin
            ev_r <= 1'b1;
            ev_code_r <= `TWC_ST_SL_STOP;
         end
         st_r <= S_SLAVE;
         cnt_r <= 4'h0;
         adr_ph_r <= 1'b1;
         addressed_r <= 1'b0;
         stx_r <= 1'b0;
         sda_lvl_r <= 1'b1;
      end else if (stop_det && !own_cond && !master_r) begin
         if (addressed_r) begin
            ev_r <= 1'b1;
            ev_code_r <= `TWC_ST_SL_STOP;
         end
         st_r <= S_IDLE;
         addressed_r <= 1'b0;
         sda_lvl_r <= 1'b1;
      end else begin
         case (st_r)
            S_IDLE: begin
               // a stale count would make the next start a bus error
               cnt_r <= 4'h0;
               scl_low_r <= 1'b0;
               sda_lvl_r <= 1'b1;
               // nothing starts while the flag is set
               if (go_r && !flag_r && !sta_r) begin
                  go_r <= 1'b0;
               end else if (go_r && !flag_r && !busy_r) begin
                  go_r <= 1'b0;
                  master_r <= 1'b1;
                  rs_r <= 1'b0;
                  tmr_r <= 15'h0000;
                  st_r <= S_START;
               end
            end
            S_START: begin
               scl_low_r <= 1'b0;
               sda_lvl_r <= 1'b1;
               if (!scl_s) begin
                  tmr_r <= 15'h0000;
               end else if (tmr_r == high_end) begin
                  sda_lvl_r <= 1'b0;
                  tmr_r <= 15'h0000;
                  st_r <= S_SDAL;
               end
            end
            S_SDAL: begin
               if (tmr_r == half_end) begin
                  scl_low_r <= 1'b1;
                  ev_r <= 1'b1;
                  ev_code_r <= rs_r ? `TWC_ST_RSTART : `TWC_ST_START;
                  adr_r <= 1'b1;
                  cnt_r <= 4'h0;
                  st_r <= S_HOLD;
               end
            end
            S_RS: begin
               scl_low_r <= 1'b1;
               sda_lvl_r <= 1'b1;
               if (tmr_r == half_end) begin
                  scl_low_r <= 1'b0;
                  tmr_r <= 15'h0000;
                  st_r <= S_START;
               end
            end
            S_HOLD: begin
               scl_low_r <= 1'b1;
               if (go_r && !flag_r) begin
                  go_r <= 1'b0;
                  tmr_r <= 15'h0000;
                  if (sto_r) begin
                     st_r <= S_STOP1;
                  end else if (sta_r) begin
                     rs_r <= 1'b1;
                     st_r <= S_RS;
                  end else begin
                     cnt_r <= 4'h0;
                     if (adr_r) begin
                        mtx_r <= ~shift_data_r[0];
                     end
                     st_r <= S_LOW;
                  end
               end
            end
            S_LOW: begin
               scl_low_r <= 1'b1;
               sda_lvl_r <= bit_val;
               if (tmr_r == half_end) begin
                  scl_low_r <= 1'b0;
                  tmr_r <= 15'h0000;
                  st_r <= S_HIGH;
               end
            end
            S_HIGH: begin
               // a stretched low restarts the high count
               if (!scl_s) begin
                  tmr_r <= 15'h0000;
               end else if (tmr_r == high_end) begin
                  scl_low_r <= 1'b1;
                  tmr_r <= 15'h0000;
                  if (cnt_r == `TWC_LAST_BIT) begin
                     // packet done, code carries the ack
                     ev_r <= 1'b1;
                     if (adr_r) begin
                        ev_code_r <= mtx_r ? (ack_in_r ? `TWC_ST_AW_NACK : `TWC_ST_AW_ACK)
                                           : (ack_in_r ? `TWC_ST_AR_NACK : `TWC_ST_AR_ACK);
                     end else if (mtx_r) begin
                        ev_code_r <= ack_in_r ? `TWC_ST_DW_NACK : `TWC_ST_DW_ACK;
                     end else begin
                        ev_code_r <= ack_out_r ? `TWC_ST_DR_ACK : `TWC_ST_DR_NACK;
                     end
                     adr_r <= 1'b0;
                     st_r <= S_HOLD;
                  end else begin
                     cnt_r <= cnt_r + 4'h1;
                     st_r <= S_LOW;
                  end
               end
               if (scl_rise) begin
                  if (cnt_r < `TWC_LAST_BIT) begin
                     // shift in what the bus shows
                     shift_data_r <= {shift_data_r[6:0], sda_s};
                     if (tx_now && sda_lvl_r && !sda_s) begin
                        master_r <= 1'b0;
                        lost_r <= 1'b1;
                        scl_low_r <= 1'b0;
                        sda_lvl_r <= 1'b1;
                        ack_out_r <= 1'b0;
                        adr_ph_r <= adr_r;
                        addressed_r <= 1'b0;
                        stx_r <= 1'b0;
                        st_r <= S_SLAVE;
                     end
                  end else begin
                     ack_in_r <= sda_s;
                  end
               end
            end
            S_STOP1: begin
               scl_low_r <= 1'b1;
               sda_lvl_r <= 1'b0;
               if (tmr_r == half_end) begin
                  scl_low_r <= 1'b0;
                  tmr_r <= 15'h0000;
                  st_r <= S_STOP2;
               end
            end
            S_STOP2: begin
               if (!scl_s) begin
                  tmr_r <= 15'h0000;
               end else if (tmr_r == high_end) begin
                  sda_lvl_r <= 1'b1;
                  tmr_r <= 15'h0000;
                  st_r <= S_STOP3;
               end
            end
            S_STOP3: begin
               // back to idle with no event
               if (tmr_r == half_end) begin
                  master_r <= 1'b0;
                  st_r <= S_IDLE;
               end
            end
            S_SLAVE: begin
               scl_low_r <= 1'b0;
               // data only changes while scl is low
               if (!scl_s) begin
                  sda_lvl_r <= bit_val;
               end
               if (scl_rise) begin
                  if (cnt_r < `TWC_LAST_BIT) begin
                     shift_data_r <= {shift_data_r[6:0], sda_s};
                  end else begin
                     ack_in_r <= sda_s;
                  end
               end
               if (scl_fall && rose_r) begin
                  if (cnt_r == `TWC_LAST_BIT) begin
                     cnt_r <= 4'h0;
                     adr_ph_r <= 1'b0;
                     lost_r <= 1'b0;
                     ev_r <= addressed_r | lost_r;
                     if (!addressed_r) begin
                        ev_code_r <= `TWC_ST_ARB_LOST;
                        st_r <= S_IDLE;
                     end else if (adr_ph_r) begin
                        // addressed by own or general call
                        ev_code_r <= stx_r ? `TWC_ST_SL_R
                                           : (gc_r ? `TWC_ST_SL_GC : `TWC_ST_SL_W);
                     end else if (stx_r) begin
                        ev_code_r <= ack_in_r ? `TWC_ST_ST_NACK : `TWC_ST_ST_ACK;
                        if (ack_in_r) begin
                           addressed_r <= 1'b0;
                           st_r <= S_IDLE;
                        end
                     end else begin
                        ev_code_r <= ack_out_r ? `TWC_ST_SR_ACK : `TWC_ST_SR_NACK;
                     end
                  end else begin
                     cnt_r <= cnt_r + 4'h1;
                     if (cnt_r == `TWC_ADR_BIT && adr_ph_r) begin
                        if (own_hit || gc_hit) begin
                           addressed_r <= 1'b1;
                           gc_r <= gc_hit & ~own_hit;
                           stx_r <= shift_data_r[0];
                           ack_out_r <= ack_en_r;
                           wake_r <= sleep_i;
                        end else begin
                           ev_r <= lost_r;
                           ev_code_r <= `TWC_ST_ARB_LOST;
                           lost_r <= 1'b0;
                           st_r <= S_IDLE;
                        end
                     end
                  end
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
assign rdata_o = rdata_r;
assign scl_o = 1'b0;
assign sda_o = 1'b0;
// hold scl while the flag waits on software
assign scl_oen_o = ~(scl_low_r | (flag_r & (st_r != S_IDLE)));
assign sda_oen_o = sda_lvl_r;
assign irq_o = flag_r & event_irq_enable_r & global_irq_en_i;
assign wake_o = wake_r;

endmodule // twc_core

// file: src/twc_map.vh
`ifndef TWC_MAP_VH
`define TWC_MAP_VH
// register offsets
`define TWC_OFS_BITRATE 3'h0
`define TWC_OFS_STATUS 3'h1
`define TWC_OFS_DATA 3'h2
`define TWC_OFS_OWNADR 3'h3
`define TWC_OFS_CTRL 3'h4
// control register fields
`define TWC_CTL_FLAG 7
`define TWC_CTL_ACK 6
`define TWC_CTL_STA 5
`define TWC_CTL_STO 4
`define TWC_CTL_EN 2
`define TWC_CTL_IE 0
// own address register field
`define TWC_OAR_GCE 0
// reset values
`define TWC_BITRATE_RST 8'h00
`define TWC_OWNADR_RST 8'h00
`define TWC_DATA_RST 8'hFF
// status codes
`define TWC_ST_NOINFO 8'hF8
`define TWC_ST_BUSERR 8'h00
`define TWC_ST_START 8'h08
`define TWC_ST_RSTART 8'h10
`define TWC_ST_AW_ACK 8'h18
`define TWC_ST_AW_NACK 8'h20
`define TWC_ST_DW_ACK 8'h28
`define TWC_ST_DW_NACK 8'h30
`define TWC_ST_ARB_LOST 8'h38
`define TWC_ST_AR_ACK 8'h40
`define TWC_ST_AR_NACK 8'h48
`define TWC_ST_DR_ACK 8'h50
`define TWC_ST_DR_NACK 8'h58
`define TWC_ST_SL_W 8'h60
`define TWC_ST_SL_GC 8'h70
`define TWC_ST_SR_ACK 8'h80
`define TWC_ST_SR_NACK 8'h88
`define TWC_ST_SL_STOP 8'hA0
`define TWC_ST_SL_R 8'hA8
`define TWC_ST_ST_ACK 8'hB8
`define TWC_ST_ST_NACK 8'hC0
// timing: half period base of 16-cycle fixed part, sync latency
`define TWC_HALF_BASE 15'h0008
`define TWC_SYNC_LAT 15'h0002
`define TWC_GC_ADDR 7'h00
`define TWC_LAST_BIT 4'h8
`define TWC_ADR_BIT 4'h7
`endif

// file: src/twc_bus_mon.v
`timescale 1ns/1ns
module twc_bus_mon (
   input wire clk_i,
   input wire rst_n_i,
   input wire scl_i,
   input wire sda_i,
   output wire scl_o,
   output wire sda_o,
   output wire scl_rise_o,
   output wire scl_fall_o,
   output wire start_o,
   output wire stop_o
);

reg [1:0] scl_sync_r;
reg [1:0] sda_sync_r;
reg scl_q_r;
reg sda_q_r;

// idle bus is high, so the chain resets high to avoid a false edge
always @(posedge clk_i or negedge rst_n_i) begin
   if (!rst_n_i) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
   end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_q_r <= scl_sync_r[1];
      sda_q_r <= sda_sync_r[1];
   end
end

assign scl_o = scl_sync_r[1];
assign sda_o = sda_sync_r[1];
assign scl_rise_o = scl_sync_r[1] & ~scl_q_r;
assign scl_fall_o = ~scl_sync_r[1] & scl_q_r;
// sda moving while scl stays high
assign start_o = scl_sync_r[1] & scl_q_r & sda_q_r & ~sda_sync_r[1];
assign stop_o = scl_sync_r[1] & scl_q_r & ~sda_q_r & sda_sync_r[1];

endmodule // twc_bus_mon

// file: verification/twc_peer_mdl.sv
`timescale 1ns/1ns
module twc_peer_mdl (
   input wire clk_i,
   input wire scl_i,
   input wire sda_i,
   input wire [7:0] stretch_i,
   output logic scl_oen_o,
   output logic sda_oen_o,
   output logic [7:0] byte_o
);
   int nb = 0;
   bit mst = 0;
   initial begin
      scl_oen_o = 1'b1;
      sda_oen_o = 1'b1;
      byte_o = 8'h00;
   end
   ////////////////////////////////////////////////////////////////
   // start resets count
   always @(negedge sda_i) if (scl_i && !mst) nb = 0;
   always @(posedge scl_i) if (!mst && nb > 0 && nb < 9) byte_o = {byte_o[6:0], sda_i};
   always @(negedge scl_i) if (!mst) begin
      nb = (nb == 9) ? 1 : nb + 1;
      sda_oen_o = (nb != 9);
      if (stretch_i != 8'h00) begin
         scl_oen_o = 1'b0;
         repeat (stretch_i) @(posedge clk_i);
         #2 scl_oen_o = 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////
   // changes land just after an edge, never on it
   task automatic half_bit;
      repeat (10) @(posedge clk_i);
      #2;
   endtask
   task automatic wait_high;
      for (int k = 0; k < 2000 && !scl_i; k++) @(posedge clk_i);
   endtask
   // bit time far above 16 cycles
   task automatic send(input logic [7:0] b, output logic ack);
      logic [8:0] bits;
      bits = {b, 1'b1};
      mst = 1'b1;
      half_bit;
      sda_oen_o = 1'b0;
      half_bit;
      for (int i = 8; i >= 0; i--) begin
         scl_oen_o = 1'b0;
         half_bit;
         sda_oen_o = bits[i];
         half_bit;
         scl_oen_o = 1'b1;
         wait_high;
         half_bit;
         ack = sda_i;
      end
      scl_oen_o = 1'b0;
      half_bit;
   endtask
   task automatic stop_cond;
      half_bit;
      sda_oen_o = 1'b0;
      half_bit;
      scl_oen_o = 1'b1;
      wait_high;
      half_bit;
      sda_oen_o = 1'b1;
      half_bit;
      mst = 1'b0;
   endtask
endmodule // twc_peer_mdl

// file: verification/twc_core_chk.sv
`timescale 1ns/1ns
`include "twc_map.vh"
module twc_core_chk (
   input wire clk_i,
   input wire rst_n_i,
   input wire [2:0] addr_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire scl_i,
   input wire scl_o,
   input wire scl_oen_o,
   input wire sda_o,
   input wire sda_oen_o,
   input wire global_irq_en_i,
   input wire sleep_i,
   input wire irq_o,
   input wire wake_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire ctl_wr = wr_i && addr_i == `TWC_OFS_CTRL;
   ////////////////////////////////////////////////////////////////
   a_irq_gating: assert property (irq_o |-> global_irq_en_i)
      else $error("irq without global enable");
   a_irq_stands: assert property (irq_o && !ctl_wr ##1 global_irq_en_i |-> irq_o)
      else $error("flag dropped without control write");
   a_scl_held: assert property (irq_o && !scl_oen_o && !ctl_wr |=> !scl_oen_o)
      else $error("scl released while flag set");
   a_low_phase: assert property ($fell(scl_oen_o) && $past(scl_i) |-> !scl_oen_o [*8])
      else $error("scl low phase too short");
   a_reset_idle: assert property ($rose(rst_n_i) |-> scl_oen_o && sda_oen_o && !irq_o)
      else $error("lines not released after reset");
   a_drive_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("open drain value not low");
   a_wake_pulse: assert property (wake_o |-> $past(sleep_i) ##1 !wake_o)
      else $error("wake pulse malformed");
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside read slot");
   c_wake: cover property (wake_o);
   c_hold: cover property (irq_o && !scl_oen_o);
   c_low: cover property ($fell(scl_oen_o) && $past(scl_i));
endmodule // twc_core_chk
bind twc_core twc_core_chk i_twc_core_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oen_o(scl_oen_o), .sda_o(sda_o), .sda_oen_o(sda_oen_o),
   .global_irq_en_i(global_irq_en_i), .sleep_i(sleep_i), .irq_o(irq_o), .wake_o(wake_o));

// file: verification/tb_top.sv
`timescale 1ns/1ns
`include "twc_map.vh"
module tb_top;
   // divider 2, prescaler 1
   localparam int PER = 16 + 2 * 2 * 4;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, gie = 0, sleep = 0, owake = 0, ack;
   logic [2:0] addr = 0;
   logic [7:0] wdata = 0, stretch = 0, v;
   logic [7:0] rst_val [6] = '{8'h00, 8'hF8, 8'hFF, 8'h00, 8'h00, 8'h00};
   logic [7:0] sl_adr [2] = '{8'h66, 8'h00};
   logic [7:0] sl_code [2] = '{`TWC_ST_SL_W, `TWC_ST_SL_GC};
   wire [7:0] rdata, p_byte;
   wire scl_oen, sda_oen, p_scl_oen, p_sda_oen, irq, wake;
   wire scl = scl_oen & p_scl_oen;
   wire sda = sda_oen & p_sda_oen;
   int n_errors = 0, n_compared = 0, n_wake = 0;
   time per = 0, last_rise = 0;
   twc_core i_twc_core (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .scl_i(scl), .scl_o(), .scl_oen_o(scl_oen),
      .sda_i(sda), .sda_o(), .sda_oen_o(sda_oen), .global_irq_en_i(gie), .sleep_i(sleep),
      .other_wake_i(owake), .irq_o(irq), .wake_o(wake));
   twc_peer_mdl i_twc_peer_mdl (.clk_i(clk), .scl_i(scl), .sda_i(sda), .stretch_i(stretch),
      .scl_oen_o(p_scl_oen), .sda_oen_o(p_sda_oen), .byte_o(p_byte));
   initial forever #20 clk = ~clk;
   always @(posedge scl) begin
      per = $time - last_rise;
      last_rise = $time;
   end
   always @(posedge clk) if (wake === 1'b1) n_wake++;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
   task automatic expr(input logic [2:0] a, input logic [7:0] e);
      rreg(a, v);
      chk(v, e);
   endtask
   task automatic wflag;
      v = 8'h00;
      for (int k = 0; k < 600 && v[7] !== 1'b1; k++) rreg(`TWC_OFS_CTRL, v);
      chk(v & 8'h80, 8'h80);
   endtask
   task automatic final_report;
      if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk({5'h00, scl_oen, sda_oen, irq}, 8'h06);
      foreach (rst_val[i]) expr(i[2:0], rst_val[i]);
      wreg(3'h5, 8'h5A);
      expr(3'h5, 8'h00);
      gie <= 1'b1;
      wreg(`TWC_OFS_BITRATE, 8'h02);
      wreg(`TWC_OFS_STATUS, 8'h01);
      expr(`TWC_OFS_STATUS, `TWC_ST_NOINFO | 8'h01);
      wreg(`TWC_OFS_CTRL, 8'hA5);
      wflag;
      chk({6'h00, irq, scl_oen}, 8'h02);
      expr(`TWC_OFS_STATUS, `TWC_ST_START | 8'h01);
      chk(v & 8'hF8, `TWC_ST_START);
      gie <= 1'b0;
      @(posedge clk);
      chk({7'h00, irq}, 8'h00);
      gie <= 1'b1;
      wreg(`TWC_OFS_DATA, 8'h54);
      wreg(`TWC_OFS_CTRL, 8'h85);
      wflag;
      expr(`TWC_OFS_STATUS, `TWC_ST_AW_ACK | 8'h01);
      chk(p_byte, 8'h54);
      chk(8'(per / 40), 8'(PER));
      stretch <= 8'd24;
      wreg(`TWC_OFS_DATA, 8'hC3);
      wreg(`TWC_OFS_CTRL, 8'h85);
      wflag;
      stretch <= 8'd0;
      expr(`TWC_OFS_STATUS, `TWC_ST_DW_ACK | 8'h01);
      chk(p_byte, 8'hC3);
      chk(8'(per / 40), 8'(24 + PER / 2));
      wreg(`TWC_OFS_CTRL, 8'h95);
      repeat (300) @(posedge clk);
      rreg(`TWC_OFS_CTRL, v);
      chk(v & 8'h80, 8'h00);
      chk({6'h00, scl_oen, sda_oen}, 8'h03);
      wreg(`TWC_OFS_OWNADR, 8'h67);
      wreg(`TWC_OFS_CTRL, 8'h44);
      sleep <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         i_twc_peer_mdl.send(sl_adr[i], ack);
         chk({7'h00, ack}, 8'h00);
         wflag;
         sleep <= 1'b0;
         expr(`TWC_OFS_STATUS, sl_code[i] | 8'h01);
         wreg(`TWC_OFS_CTRL, 8'hC4);
         i_twc_peer_mdl.stop_cond;
         wflag;
         expr(`TWC_OFS_STATUS, `TWC_ST_SL_STOP | 8'h01);
         wreg(`TWC_OFS_CTRL, 8'hC4);
      end
      chk(8'(n_wake), 8'h01);
      i_twc_peer_mdl.send(8'h40, ack);
      chk({7'h00, ack}, 8'h01);
      rreg(`TWC_OFS_CTRL, v);
      chk(v & 8'h80, 8'h00);
      i_twc_peer_mdl.stop_cond;
      // foreign wake while a sleeping match runs
      @(posedge clk);
      sleep <= 1'b1;
      owake <= 1'b1;
      i_twc_peer_mdl.send(8'h66, ack);
      chk({7'h00, ack}, 8'h01);
      rreg(`TWC_OFS_CTRL, v);
      chk(v & 8'h80, 8'h00);
      i_twc_peer_mdl.stop_cond;
      final_report;
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      final_report;
   end
endmodule // tb_top
